// >>> irq_enable_pkg.sv
// constants, field layouts and helpers for the interrupt enable bank
// Overview of operation
// - an enable bit of one passes its source request on; zero blocks it
// - bit 15 word0, bit 2 word1, bit 13 word2 ignore writes, read zero
// - word0 bits 14..8: dma1 done, adc1, uart1 tx, uart1 rx, spi1 event, error, timer3
// - word0 bits 7..0: timer2, oc2, ic2, dma0 done, timer1, oc1, ic1, ext irq0
// - word1 bits 15..8: uart2 tx, uart2 rx, ext irq2, timer5, timer4, oc4, oc3, dma2
// - word1 bits 7..0: ic8, ic7, adc2, ext irq1, pin change, unused, i2c1 master, slave
// - word2 bits 15..8: timer6, dma4, unused, oc8, oc7, oc6, oc5, ic6
// - word2 bits 7..0: ic5, ic4, ic3, dma3, can1 event, can1 rx, spi2 event, spi2 error
// - a source is presented only when its pending flag and enable are both one
// - three-bit priority per source; zero disables, seven is highest
package irq_enable_pkg;
  // byte offsets on the bus
  localparam logic [7:0] OFS_EN0    = 8'h00;
  localparam logic [7:0] OFS_EN1    = 8'h04;
  localparam logic [7:0] OFS_EN2    = 8'h08;
  localparam logic [7:0] OFS_FLAG0  = 8'h0C;
  localparam logic [7:0] OFS_FLAG1  = 8'h10;
  localparam logic [7:0] OFS_FLAG2  = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_MASK   = 8'h1C;
  localparam logic [7:0] OFS_PRIO   = 8'h20;
  localparam logic [3:0] PRIO_WORDS = 4'hC;
  localparam logic [3:0] PRIO_LAST  = 4'hB;
  // implemented bits of each enable / flag word
  localparam logic [15:0] IMPL0 = 16'h7FFF;
  localparam logic [15:0] IMPL1 = 16'hFFFB;
  localparam logic [15:0] IMPL2 = 16'hDFFF;
  // reset values
  localparam logic [15:0] EN_RESET   = 16'h0000;
  localparam logic [11:0] PRIO_RESET = 12'h0924;
  localparam logic [1:0]  STAT_RESET = 2'h0;
  // status bit positions
  localparam int ST_PRESENT = 0;
  localparam int ST_BADADR  = 1;
  // cycles from request to ack
  localparam int ACK_CYCLES = 2;

  // merge 16-bit write data under byte lanes
  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [15:0] wd,
                                             input logic [3:0] sel);
    lane_merge = {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
  endfunction

  // four packed 3-bit fields to the 16-bit register image
  function automatic logic [15:0] prio_unpack(input logic [11:0] w);
    prio_unpack = {1'b0, w[11:9], 1'b0, w[8:6], 1'b0, w[5:3], 1'b0, w[2:0]};
  endfunction

  function automatic logic [11:0] prio_pack(input logic [15:0] r);
    prio_pack = {r[14:12], r[10:8], r[6:4], r[2:0]};
  endfunction
endpackage

// >>> flag_bank.sv
// sticky pending flags for one word of sources
`timescale 1ns/100ps
module flag_bank
  import irq_enable_pkg::*;
#(
  parameter logic [15:0] IMPL = 16'hFFFF
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // set by sources, cleared by software
  input  wire logic [15:0] set_in,
  input  wire logic [15:0] clr_in,
  output logic      [15:0] flags
);
  logic [15:0] next_flags;

  // set beats a clear in the same cycle
  always_comb begin
    next_flags = ((flags & ~clr_in) | set_in) & IMPL;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      flags <= EN_RESET;
    end else begin
      flags <= next_flags;
    end
  end
endmodule

// >>> prio_mem.sv
// priority field store, one bus read port and one scan read port
`timescale 1ns/100ps
module prio_mem
  import irq_enable_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // write port
  input  wire logic        we,
  input  wire logic [3:0]  waddr,
  input  wire logic [11:0] wdata,
  // registered read ports
  input  wire logic [3:0]  raddr_a,
  output logic      [11:0] rdata_a,
  input  wire logic [3:0]  raddr_b,
  output logic      [11:0] rdata_b
);
  logic [11:0] mem [12];

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < 12; i++) begin
        mem[i] <= PRIO_RESET;
      end
      rdata_a <= 12'h0000;
      rdata_b <= 12'h0000;
    end else begin
      if (we && waddr < PRIO_WORDS) begin
        mem[waddr] <= wdata;
      end
      rdata_a <= (raddr_a < PRIO_WORDS) ? mem[raddr_a] : 12'h0000;
      rdata_b <= (raddr_b < PRIO_WORDS) ? mem[raddr_b] : 12'h0000;
    end
  end
endmodule

// >>> irq_enable_bank.sv
// interrupt enable bank with pending flags, priority scan and wishbone slave
`timescale 1ns/100ps
module irq_enable_bank
  import irq_enable_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // source requests, one bit per source
  input  wire logic [15:0] src_req0,
  input  wire logic [15:0] src_req1,
  input  wire logic [15:0] src_req2,
  // gated requests toward the core
  output logic      [15:0] gated_req0,
  output logic      [15:0] gated_req1,
  output logic      [15:0] gated_req2,
  // winning request
  output logic             core_irq_valid,
  output logic      [5:0]  core_irq_id,
  output logic      [2:0]  core_irq_level,
  // block interrupt
  output logic             irq
);
  // register state
  logic [15:0] en0;
  logic [15:0] en1;
  logic [15:0] en2;
  logic [15:0] next_en0;
  logic [15:0] next_en1;
  logic [15:0] next_en2;
  logic [1:0]  status;
  logic [1:0]  next_status;
  logic [1:0]  mask;
  logic [1:0]  next_mask;
  logic        phase;
  logic        next_phase;
  logic        next_ack;
  logic [31:0] next_dat;
  logic        next_irq;
  logic [15:0] clr0;
  logic [15:0] clr1;
  logic [15:0] clr2;
  logic [15:0] flag0;
  logic [15:0] flag1;
  logic [15:0] flag2;
  logic        mem_we;
  logic [11:0] mem_wdata;
  logic [11:0] rdata_a;
  logic [11:0] rdata_b;
  logic [3:0]  pidx;
  logic        is_prio;
  logic        acc;
  logic        wr;
  logic [15:0] wd;
  logic [7:0]  adr;

  assign adr     = {wb_adr_i[7:2], 2'b00};
  assign wd      = wb_dat_i[15:0];
  assign acc     = phase || wr;
  assign wr      = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i;
  assign is_prio = adr >= OFS_PRIO && adr < 8'(OFS_PRIO + 8'h30);
  assign pidx    = 4'(wb_adr_i[7:2] - 6'd8);

  flag_bank #(.IMPL(IMPL0)) u_flag0 (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .set_in   (src_req0),
    .clr_in   (clr0),
    .flags    (flag0)
  );

  flag_bank #(.IMPL(IMPL1)) u_flag1 (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .set_in   (src_req1),
    .clr_in   (clr1),
    .flags    (flag1)
  );

  flag_bank #(.IMPL(IMPL2)) u_flag2 (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .set_in   (src_req2),
    .clr_in   (clr2),
    .flags    (flag2)
  );

  // scanner state
  logic [3:0]  scan_idx;
  logic [3:0]  next_scan_idx;
  logic [3:0]  data_idx;
  logic [3:0]  next_data_idx;
  logic        data_ok;
  logic        next_data_ok;
  logic [2:0]  best_lvl;
  logic [2:0]  next_best_lvl;
  logic [5:0]  best_id;
  logic [5:0]  next_best_id;
  logic        next_valid;
  logic [5:0]  next_id;
  logic [2:0]  next_level;
  logic [47:0] pres;

  assign pres = {gated_req2, gated_req1, gated_req0};

  prio_mem u_prio (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .we       (mem_we),
    .waddr    (pidx),
    .wdata    (mem_wdata),
    .raddr_a  (pidx),
    .rdata_a  (rdata_a),
    .raddr_b  (scan_idx),
    .rdata_b  (rdata_b)
  );

  // bus slave: request taken, answered two cycles later
  always_comb begin
    next_phase  = !phase && !wb_ack_o && wb_cyc_i && wb_stb_i;
    next_ack    = phase;
    next_dat    = 32'h0000_0000;
    next_en0    = en0;
    next_en1    = en1;
    next_en2    = en2;
    next_mask   = mask;
    next_status = status;
    clr0        = 16'h0000;
    clr1        = 16'h0000;
    clr2        = 16'h0000;
    mem_we      = 1'b0;
    mem_wdata   = prio_pack(lane_merge(prio_unpack(rdata_a), wd, wb_sel_i));
    if (acc) begin
      if (is_prio) begin
        next_dat[15:0] = prio_unpack(rdata_a);
        mem_we         = wr;
      end else begin
        unique case (adr)
          OFS_EN0: begin
            next_dat[15:0] = en0;
            if (wr) next_en0 = lane_merge(en0, wd, wb_sel_i) & IMPL0;
          end
          OFS_EN1: begin
            next_dat[15:0] = en1;
            if (wr) next_en1 = lane_merge(en1, wd, wb_sel_i) & IMPL1;
          end
          OFS_EN2: begin
            next_dat[15:0] = en2;
            if (wr) next_en2 = lane_merge(en2, wd, wb_sel_i) & IMPL2;
          end
          OFS_FLAG0: begin
            next_dat[15:0] = flag0;
            if (wr) clr0 = lane_merge(16'h0000, wd, wb_sel_i);
          end
          OFS_FLAG1: begin
            next_dat[15:0] = flag1;
            if (wr) clr1 = lane_merge(16'h0000, wd, wb_sel_i);
          end
          OFS_FLAG2: begin
            next_dat[15:0] = flag2;
            if (wr) clr2 = lane_merge(16'h0000, wd, wb_sel_i);
          end
          OFS_STATUS: begin
            next_dat[1:0] = status;
            if (wr && wb_sel_i[0]) next_status = status & ~wd[1:0];
          end
          OFS_MASK: begin
            next_dat[1:0] = mask;
            if (wr && wb_sel_i[0]) next_mask = wd[1:0];
          end
          default: begin
            next_status[ST_BADADR] = 1'b1;
          end
        endcase
      end
    end
    // read data only in the cycle before ack; writes land with ack
    if (!phase) begin
      next_dat = 32'h0000_0000;
    end
    // a new presentation sets its status bit, winning over a clear
    if (next_valid && !core_irq_valid) begin
      next_status[ST_PRESENT] = 1'b1;
    end
    next_irq = |(next_status & next_mask);
  end

  // priority scan, four sources per cycle, twelve words per sweep
  always_comb begin
    next_scan_idx = (scan_idx == PRIO_LAST) ? 4'h0 : 4'(scan_idx + 4'h1);
    next_data_idx = scan_idx;
    next_data_ok  = 1'b1;
    next_best_lvl = best_lvl;
    next_best_id  = best_id;
    next_valid    = core_irq_valid;
    next_id       = core_irq_id;
    next_level    = core_irq_level;
    if (data_ok) begin
      for (int k = 0; k < 4; k++) begin
        if (pres[6'(data_idx * 4 + k)] && rdata_b[k*3 +: 3] != 3'h0
            && rdata_b[k*3 +: 3] > next_best_lvl) begin
          next_best_lvl = rdata_b[k*3 +: 3];
          next_best_id  = 6'(data_idx * 4 + k);
        end
      end
      if (data_idx == PRIO_LAST) begin
        next_valid    = next_best_lvl != 3'h0;
        next_id       = next_best_id;
        next_level    = next_best_lvl;
        next_best_lvl = 3'h0;
        next_best_id  = 6'h00;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      en0            <= EN_RESET;
      en1            <= EN_RESET;
      en2            <= EN_RESET;
      status         <= STAT_RESET;
      mask           <= STAT_RESET;
      phase          <= 1'b0;
      wb_ack_o       <= 1'b0;
      wb_dat_o       <= 32'h0000_0000;
      irq            <= 1'b0;
      gated_req0     <= 16'h0000;
      gated_req1     <= 16'h0000;
      gated_req2     <= 16'h0000;
      scan_idx       <= 4'h0;
      data_idx       <= 4'h0;
      data_ok        <= 1'b0;
      best_lvl       <= 3'h0;
      best_id        <= 6'h00;
      core_irq_valid <= 1'b0;
      core_irq_id    <= 6'h00;
      core_irq_level <= 3'h0;
    end else begin
      en0            <= next_en0;
      en1            <= next_en1;
      en2            <= next_en2;
      status         <= next_status;
      mask           <= next_mask;
      phase          <= next_phase;
      wb_ack_o       <= next_ack;
      wb_dat_o       <= next_dat;
      irq            <= next_irq;
      gated_req0     <= flag0 & en0;
      gated_req1     <= flag1 & en1;
      gated_req2     <= flag2 & en2;
      scan_idx       <= next_scan_idx;
      data_idx       <= next_data_idx;
      data_ok        <= next_data_ok;
      best_lvl       <= next_best_lvl;
      best_id        <= next_best_id;
      core_irq_valid <= next_valid;
      core_irq_id    <= next_id;
      core_irq_level <= next_level;
    end
  end

  // checks
  sequence s_req_start;
    !wb_ack_o && !phase && wb_cyc_i && wb_stb_i;
  endsequence

  a_ack_latency: assert property (@(posedge core_clk) disable iff (!rst_b)
    s_req_start |=> !wb_ack_o ##1 wb_ack_o ##1 !wb_ack_o)
    else $error("ack not two cycles after request");

  a_unused_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
    !en0[15] && !en1[2] && !en2[13] && !gated_req0[15] && !gated_req1[2] && !gated_req2[13])
    else $error("unimplemented enable bit set");

  a_gate_block: assert property (@(posedge core_clk) disable iff (!rst_b)
    ##1 (gated_req0 == ($past(flag0) & $past(en0))) && (gated_req2 == ($past(flag2) & $past(en2))))
    else $error("gated request does not follow flag and enable");

  a_reset_clear: assert property (@(posedge core_clk)
    !rst_b |=> en0 == 16'h0000 && en1 == 16'h0000 && en2 == 16'h0000)
    else $error("enable not cleared by reset");

  a_write_en0: assert property (@(posedge core_clk) disable iff (!rst_b)
    wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && adr == OFS_EN0 && wb_sel_i[1:0] == 2'b11
      |=> en0 == ($past(wd) & IMPL0))
    else $error("enable word0 write lost");

  a_flag_set_wins: assert property (@(posedge core_clk) disable iff (!rst_b)
    src_req1[0] |=> flag1[0])
    else $error("source request lost against clear");

  a_prio_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
    core_irq_valid |-> core_irq_level != 3'h0)
    else $error("presented request with priority zero");

  a_present_needs: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(core_irq_valid) |-> $past(pres != 48'h0, 2) || $past(pres != 48'h0, 3)
      || $past(pres != 48'h0, 1))
    else $error("presented with no gated request");

  a_irq_level: assert property (@(posedge core_clk) disable iff (!rst_b)
    irq == |(status & mask))
    else $error("irq not status and mask");
endmodule

// >>> core_model.sv
// model of the core side that takes the winning request
`timescale 1ns/100ps
module core_model (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // winning request from the bank
  input  wire logic       core_irq_valid,
  input  wire logic [5:0] core_irq_id,
  input  wire logic [2:0] core_irq_level,
  // request taken, cleared while core_irq_valid is low
  output logic            taken,
  output logic      [5:0] taken_id,
  output logic      [2:0] taken_level
);
  // latches the presented request, as the vectoring logic would
  always_ff @(posedge core_clk) begin
    if (!rst_b || !core_irq_valid) begin
      taken       <= 1'b0;
      taken_id    <= 6'h00;
      taken_level <= 3'h0;
    end else begin
      taken       <= 1'b1;
      taken_id    <= core_irq_id;
      taken_level <= core_irq_level;
    end
  end
endmodule

// >>> tb.sv
// testbench for the interrupt enable bank
`timescale 1ns/100ps
module tb;
  import irq_enable_pkg::*;
  logic core_clk = 1'b0, rst_b = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, q;
  logic wb_ack_o, core_irq_valid, irq, taken;
  logic [15:0] src_req0 = 16'h0000, src_req1 = 16'h0000, src_req2 = 16'h0000;
  logic [15:0] gated_req0, gated_req1, gated_req2, g;
  logic [5:0] core_irq_id, taken_id;
  logic [2:0] core_irq_level, taken_level;
  int errors = 0, samples_checked = 0;
  logic [15:0] impl [3] = '{16'h7FFF, 16'hFFFB, 16'hDFFF};

  always #12.5 core_clk = ~core_clk;

  irq_enable_bank DUT (.core_clk(core_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .src_req0(src_req0),
    .src_req1(src_req1), .src_req2(src_req2), .gated_req0(gated_req0),
    .gated_req1(gated_req1), .gated_req2(gated_req2), .core_irq_valid(core_irq_valid),
    .core_irq_id(core_irq_id), .core_irq_level(core_irq_level), .irq(irq));
  core_model core (.core_clk(core_clk), .rst_b(rst_b), .core_irq_valid(core_irq_valid),
    .core_irq_id(core_irq_id), .core_irq_level(core_irq_level), .taken(taken),
    .taken_id(taken_id), .taken_level(taken_level));

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  // one classic cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'h3;
    wb_dat_i <= {16'h0000, d};
    do begin
      @(posedge core_clk);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 16'h0000);
    chk(exp, q);
  endtask

  task automatic t_regs;
    for (int w = 0; w < 3; w++) begin
      rd(8'(4 * w), 32'h0000_0000);
      bus(1'b1, 8'(4 * w), 16'hFFFF);
      rd(8'(4 * w), {16'h0000, impl[w]});
      bus(1'b1, 8'(4 * w), 16'h0000);
    end
    rd(8'h20, 32'h0000_4444);
  endtask

  task automatic t_irq;
    rd(8'h80, 32'h0000_0000);
    rd(8'h18, 32'h0000_0002);
    chk(32'(1'b0), 32'(irq));
    bus(1'b1, 8'h1C, 16'h0002);
    repeat (2) @(posedge core_clk);
    chk(32'(1'b1), 32'(irq));
    bus(1'b1, 8'h18, 16'h0002);
    repeat (2) @(posedge core_clk);
    chk(32'(1'b0), 32'(irq));
  endtask

  task automatic t_gate;
    @(posedge core_clk) src_req0 <= 16'h0011;
    @(posedge core_clk) src_req0 <= 16'h0000;
    repeat (4) @(posedge core_clk);
    chk(32'h0000_0000, 32'(gated_req0));
    rd(8'h0C, 32'h0000_0011);
    bus(1'b1, 8'h20, 16'h4447);
    bus(1'b1, 8'h00, 16'h0001);
    repeat (2) @(posedge core_clk);
    chk(32'h0000_0001, 32'(gated_req0));
    repeat (60) @(posedge core_clk);
    chk({1'b1, 6'h00, 3'h7}, {taken, taken_id, taken_level});
    rd(8'h18, 32'h0000_0001);
    bus(1'b1, 8'h20, 16'h4440);
    repeat (60) @(posedge core_clk);
    chk(32'(1'b0), 32'(core_irq_valid));
  endtask

  // walking enable over every bit with all flags pending
  task automatic t_walk;
    @(posedge core_clk);
    src_req0 <= 16'hFFFF;
    src_req1 <= 16'hFFFF;
    src_req2 <= 16'hFFFF;
    @(posedge core_clk);
    src_req0 <= 16'h0000;
    src_req1 <= 16'h0000;
    src_req2 <= 16'h0000;
    for (int w = 0; w < 3; w++) begin
      for (int b = 0; b < 16; b++) begin
        bus(1'b1, 8'(4 * w), 16'h0001 << b);
        repeat (2) @(posedge core_clk);
        g = (w == 0) ? gated_req0 : (w == 1) ? gated_req1 : gated_req2;
        chk(32'((16'h0001 << b) & impl[w]), 32'(g));
      end
      bus(1'b1, 8'(4 * w), 16'h0000);
    end
  endtask

  // a source held high keeps its flag through a write-one clear
  task automatic t_flags;
    @(posedge core_clk);
    src_req1 <= 16'h0001;
    bus(1'b1, 8'h10, 16'hFFFF);
    rd(8'h10, 32'h0000_0001);
    src_req1 <= 16'h0000;
    bus(1'b1, 8'h10, 16'hFFFF);
    rd(8'h10, 32'h0000_0000);
  endtask

  // reset in mid-run clears every enable
  task automatic t_rst;
    bus(1'b1, 8'h04, 16'hFFFF);
    rd(8'h04, 32'h0000_FFFB);
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    for (int w = 0; w < 3; w++) begin
      rd(8'(4 * w), 32'h0000_0000);
    end
  endtask

  task automatic conclude;
    if (errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #(25 * 20000);
    errors++;
    conclude();
  end

  initial begin
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    t_regs();
    t_irq();
    t_gate();
    t_walk();
    t_flags();
    t_rst();
    conclude();
  end
endmodule
